// file: pcpc_pkg.sv
package pcpc_pkg;

   // Register offsets on the host control port
   localparam logic [7:0] ADDR_MISC_CONFIG = 8'h11;
   localparam logic [7:0] ADDR_CLOCK_SYNC  = 8'h12;
   localparam logic [7:0] ADDR_SUPPLY_MON  = 8'h13;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h21;
   localparam logic [7:0] ADDR_LIVE_STATUS = 8'h22;

   // Values held while reset is asserted, before the OTP load
   localparam logic [7:0] MISC_CONFIG_RST = 8'h3c;
   localparam logic [7:0] CLOCK_SYNC_RST  = 8'h02;
   localparam logic [7:0] SUPPLY_MON_RST  = 8'h00;
   localparam logic [7:0] IRQ_STATUS_RST  = 8'h00;
   localparam logic [7:0] IRQ_MASK_RST    = 8'h00;

   // Misc power config fields
   localparam int CFG_RISE_SCALE_BIT = 7;
   localparam int CFG_FALL_SCALE_BIT = 6;
   localparam int CFG_SYNC_PD_BIT    = 5;
   localparam int CFG_ENABLE_PIN_THREE_PULLDOWN_BIT     = 4;
   localparam int CFG_ENABLE_PIN_TWO_PULLDOWN_BIT     = 3;
   localparam int CFG_ENABLE_PIN_ONE_PULLDOWN_BIT     = 2;
   localparam int CFG_THERM_BIT      = 1;
   localparam int CFG_DITHER_BIT     = 0;

   // Clock sync control fields
   localparam int CS_PLL_EN_BIT = 6;
   localparam int CS_FRAC_BIT   = 5;
   localparam int CS_RATE_LSB   = 0;
   localparam int CS_RATE_MSB   = 4;
   localparam logic [4:0] RATE_MAX_CODE = 5'h17;

   // Supply monitor enable fields
   localparam int SM_WINDOW_BIT   = 6;
   localparam int SM_ANALOG_BIT   = 5;
   localparam int SM_MON_TWO_BIT  = 4;
   localparam int SM_MON_ONE_BIT  = 3;
   localparam int SM_STEPUP_BIT   = 2;
   localparam int SM_STEPDN1_BIT  = 1;
   localparam int SM_STEPDN0_BIT  = 0;
   localparam logic [7:0] SM_RECONFIG_MASK = 8'h7f;

   // Interrupt status bits
   localparam int IRQ_CLK_APPEAR_BIT = 0;
   localparam int IRQ_CLK_LOST_BIT   = 1;
   localparam int IRQ_RECONFIG_BIT   = 2;
   localparam int IRQ_RISE_DONE_BIT  = 3;
   localparam int IRQ_FALL_DONE_BIT  = 4;
   localparam logic [7:0] IRQ_IMPL_MASK = 8'h1f;

   // Timing
   localparam int CLK_PERIOD_PS    = 10000;
   localparam int HALF_MS_NS       = 500000;
   localparam int HALF_MS_CYCLES   = (HALF_MS_NS * 1000) / CLK_PERIOD_PS;
   localparam int CLK_LOSS_NS      = 2000;
   localparam int CLK_LOSS_CYCLES  = (CLK_LOSS_NS * 1000) / CLK_PERIOD_PS;

   // Sync input presence detector
   typedef enum logic [0:0] {
      PCPC_CLK_ABSENT  = 1'b0,
      PCPC_CLK_PRESENT = 1'b1
   } pcpc_clk_state_t;

   // Delay timer
   typedef enum logic [0:0] {
      PCPC_TMR_IDLE = 1'b0,
      PCPC_TMR_RUN  = 1'b1
   } pcpc_tmr_state_t;

endpackage

// file: pcpc_delay_timer.sv
`timescale 1ns/1ps

module pcpc_delay_timer #(
   parameter int UNIT_CYCLES = 50000
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       start,
   input  wire logic [3:0] code,
   input  wire logic       double_step,
   output logic            busy,
   output logic            done
);
   import pcpc_pkg::*;

   localparam int PW = $clog2(UNIT_CYCLES) + 1;
   localparam logic [PW-1:0] UNIT_LAST = PW'(UNIT_CYCLES - 1);

   pcpc_tmr_state_t state_q;
   logic [PW-1:0]   prescale_q;
   logic [4:0]      units_q;

   // Half-millisecond units left; one code step is two units when doubled
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q    <= PCPC_TMR_IDLE;
         prescale_q <= '0;
         units_q    <= 5'h00;
         done       <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            // A new edge restarts the count, the old one is dropped
            state_q    <= PCPC_TMR_RUN;
            prescale_q <= '0;
            units_q    <= double_step ? {code, 1'b0} : {1'b0, code};
         end else begin
            case (state_q)
               PCPC_TMR_RUN: begin
                  if (units_q == 5'h00) begin
                     done    <= 1'b1;
                     state_q <= PCPC_TMR_IDLE;
                  end else if (prescale_q == UNIT_LAST) begin
                     prescale_q <= '0;
                     units_q    <= units_q - 5'h01;
                  end else begin
                     prescale_q <= prescale_q + PW'(1);
                  end
               end
               default: begin
                  state_q <= PCPC_TMR_IDLE;
               end
            endcase
         end
      end
   end

   assign busy = (state_q == PCPC_TMR_RUN);

endmodule // pcpc_delay_timer

// file: pcpc_regs.sv
`timescale 1ns/1ps

// How it works
// - Startup scale clear gives 0.5 ms steps, set gives 1 ms steps.
// - Shutdown scale clear gives 0.5 ms steps, set gives 1 ms steps.
// - Config bit 5 drives the sync input pull-down, default on.
// - Config bits 4..2 drive enable pin three, two, one pull-downs, default on.
// - Thermal level bit picks 125 C when clear, 140 C when set.
// - Config bit 0 turns on clock dithering for the converters.
// - PLL bit 6 clear keeps PLL off and RC oscillator only.
// - PLL bit set runs PLL when powered, uses sync clock when present.
// - With PLL on, sync clock appearing or vanishing raises an interrupt.
// - Five-bit rate code means code plus one MHz; above 0x17 reserved.
// - Window bit 6 picks undervoltage-only or over-and-under monitoring.
// - Supply monitor bits 5..0 enable each check, all off at reset.
// - Changing any monitor enable or window bit raises an interrupt.
// - After reset every config field loads from OTP values.
// - Startup delay is code times 0.5 ms, or times 1 ms scaled.
module pcpc_regs #(
   parameter int UNIT_CYCLES = pcpc_pkg::HALF_MS_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic [7:0] otp_misc_config,
   input  wire logic [7:0] otp_clock_sync,
   input  wire logic [7:0] otp_supply_mon,
   input  wire logic       device_powered,
   input  wire logic       sync_input_pin,
   input  wire logic       delay_control,
   input  wire logic [3:0] rise_code,
   input  wire logic [3:0] fall_code,
   output logic            sync_input_pulldown,
   output logic            enable_pin_one_pulldown,
   output logic            enable_pin_two_pulldown,
   output logic            enable_pin_three_pulldown,
   output logic            thermal_alarm_level,
   output logic            dither_enable,
   output logic            pll_enable,
   output logic            use_sync_clock,
   output logic      [4:0] sync_input_rate,
   output logic            supply_window_mode,
   output logic            analog_supply_check_enable,
   output logic            monitor_two_check_enable,
   output logic            monitor_one_check_enable,
   output logic            stepup_check_enable,
   output logic            stepdown_one_check_enable,
   output logic            stepdown_zero_check_enable,
   output logic            rise_delay_done,
   output logic            fall_delay_done,
   output logic            irq
);
   import pcpc_pkg::*;

   localparam logic [11:0] LOSS_LAST = 12'(CLK_LOSS_CYCLES - 1);

   // Hardware set wins over a software clear in the same cycle
   function automatic logic [7:0] sticky(input logic [7:0] cur,
                                         input logic [7:0] set,
                                         input logic [7:0] clr);
      sticky = (cur & ~clr) | set;
   endfunction

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      hit = (addr == target);
   endfunction

   logic [7:0]      misc_config_q;
   logic [7:0]      clock_sync_q;
   logic [7:0]      supply_mon_q;
   logic [7:0]      irq_status_q;
   logic [7:0]      irq_mask_q;
   logic            otp_load_q;
   logic            sw_wr;
   logic [7:0]      irq_set;
   logic [7:0]      irq_clr;
   logic [7:0]      live_status;
   pcpc_clk_state_t clk_state_q;
   logic [11:0]     gap_q;
   logic            pin_prev_q;
   logic            pin_edge;
   logic            clk_appear;
   logic            clk_lost;
   logic            ctrl_prev_q;
   logic            rise_busy;
   logic            fall_busy;
   logic            rise_done_p;
   logic            fall_done_p;
   logic            rise_start;
   logic            fall_start;

   // Software writes are held off during the single OTP load cycle
   // Hazard: a write in that cycle is lost
   assign sw_wr = reg_wr && !otp_load_q;

   // Load pending flag: set by reset, drops after the first edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         otp_load_q <= 1'b1;
      end else begin
         otp_load_q <= 1'b0;
      end
   end

   // Misc power config: scales, pull-downs, thermal level, dithering
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         misc_config_q <= MISC_CONFIG_RST;
      end else if (otp_load_q) begin
         misc_config_q <= otp_misc_config;
      end else if (sw_wr && hit(reg_addr, ADDR_MISC_CONFIG)) begin
         misc_config_q <= reg_wdata;
      end
   end

   // Clock sync control; reserved bit 7 is kept as written
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clock_sync_q <= CLOCK_SYNC_RST;
      end else if (otp_load_q) begin
         clock_sync_q <= otp_clock_sync;
      end else if (sw_wr && hit(reg_addr, ADDR_CLOCK_SYNC)) begin
         // Fractional divider bit is stored only; software keeps it zero
         // Rate is taken as written; software stops the PLL first
         clock_sync_q <= reg_wdata;
      end
   end

   // Supply monitor enables and window mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         supply_mon_q <= SUPPLY_MON_RST;
      end else if (otp_load_q) begin
         supply_mon_q <= otp_supply_mon;
      end else if (sw_wr && hit(reg_addr, ADDR_SUPPLY_MON)) begin
         supply_mon_q <= reg_wdata;
      end
   end

   // Sync input presence: any edge marks it present, a long gap absent
   // The gap count saturates, so a dead pin holds still
   assign pin_edge = sync_input_pin ^ pin_prev_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_prev_q  <= 1'b0;
         gap_q       <= 12'h000;
         clk_state_q <= PCPC_CLK_ABSENT;
      end else begin
         pin_prev_q <= sync_input_pin;
         if (pin_edge) begin
            gap_q <= 12'h000;
         end else if (gap_q != LOSS_LAST) begin
            gap_q <= gap_q + 12'h001;
         end
         case (clk_state_q)
            PCPC_CLK_ABSENT: begin
               if (pin_edge) begin
                  clk_state_q <= PCPC_CLK_PRESENT;
               end
            end
            PCPC_CLK_PRESENT: begin
               if (!pin_edge && gap_q == LOSS_LAST) begin
                  clk_state_q <= PCPC_CLK_ABSENT;
               end
            end
            default: begin
               clk_state_q <= PCPC_CLK_ABSENT;
            end
         endcase
      end
   end

   // Presence changes count as events only while the PLL bit is set
   assign clk_appear = clock_sync_q[CS_PLL_EN_BIT] && pin_edge &&
                       (clk_state_q == PCPC_CLK_ABSENT);
   assign clk_lost   = clock_sync_q[CS_PLL_EN_BIT] && !pin_edge && gap_q == LOSS_LAST &&
                       (clk_state_q == PCPC_CLK_PRESENT);

   // PLL runs only when enabled and the device is in standby or active
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pll_enable     <= 1'b0;
         use_sync_clock <= 1'b0;
      end else begin
         pll_enable     <= clock_sync_q[CS_PLL_EN_BIT] && device_powered;
         use_sync_clock <= clock_sync_q[CS_PLL_EN_BIT] && device_powered &&
                           (clk_state_q == PCPC_CLK_PRESENT);
      end
   end

   // Startup and shutdown delay timers on the control signal edges
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_prev_q <= 1'b0;
      end else begin
         ctrl_prev_q <= delay_control;
      end
   end

   // Control edges; a level high at reset release counts as a rise
   assign rise_start = delay_control && !ctrl_prev_q;
   assign fall_start = !delay_control && ctrl_prev_q;

   // Codes are taken at the edge only
   pcpc_delay_timer #(
      .UNIT_CYCLES (UNIT_CYCLES)
   ) u_rise_timer (
      .clk         (clk),
      .rstn        (rstn),
      .start       (rise_start),
      .code        (rise_code),
      .double_step (misc_config_q[CFG_RISE_SCALE_BIT]),
      .busy        (rise_busy),
      .done        (rise_done_p)
   );

   pcpc_delay_timer #(
      .UNIT_CYCLES (UNIT_CYCLES)
   ) u_fall_timer (
      .clk         (clk),
      .rstn        (rstn),
      .start       (fall_start),
      .code        (fall_code),
      .double_step (misc_config_q[CFG_FALL_SCALE_BIT]),
      .busy        (fall_busy),
      .done        (fall_done_p)
   );

   // Delay completion pulses, registered once more for the pins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rise_delay_done <= 1'b0;
         fall_delay_done <= 1'b0;
      end else begin
         rise_delay_done <= rise_done_p;
         fall_delay_done <= fall_done_p;
      end
   end

   // Interrupt sources
   always_comb begin
      irq_set = 8'h00;
      irq_set[IRQ_CLK_APPEAR_BIT] = clk_appear;
      irq_set[IRQ_CLK_LOST_BIT]   = clk_lost;
      // Any change of the monitor set-up may glitch the checks, so flag it
      irq_set[IRQ_RECONFIG_BIT]   = sw_wr && hit(reg_addr, ADDR_SUPPLY_MON) &&
                                    (((reg_wdata ^ supply_mon_q) & SM_RECONFIG_MASK) != 8'h00);
      irq_set[IRQ_RISE_DONE_BIT]  = rise_done_p;
      irq_set[IRQ_FALL_DONE_BIT]  = fall_done_p;
   end

   // Clear mask is the write data itself
   assign irq_clr = (sw_wr && hit(reg_addr, ADDR_IRQ_STATUS)) ? reg_wdata : 8'h00;

   // Sticky status, write one to clear
   // Unused bits read zero whatever is written
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_status_q <= IRQ_STATUS_RST;
      end else begin
         irq_status_q <= sticky(irq_status_q, irq_set, irq_clr) & IRQ_IMPL_MASK;
      end
   end

   // Interrupt mask, one enables the matching status bit
   // Mask starts clear, so irq stays low until set up
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_mask_q <= IRQ_MASK_RST;
      end else if (sw_wr && hit(reg_addr, ADDR_IRQ_MASK)) begin
         irq_mask_q <= reg_wdata & IRQ_IMPL_MASK;
      end
   end

   // Level interrupt, one cycle behind the status bits
   // Registered so the pin never glitches
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= (irq_status_q & irq_mask_q) != 8'h00;
      end
   end

   // Live status: presence, clock choice, PLL, reserved rate, timers
   // Read-only; writes to its offset are ignored
   always_comb begin
      live_status    = 8'h00;
      live_status[0] = (clk_state_q == PCPC_CLK_PRESENT);
      live_status[1] = use_sync_clock;
      live_status[2] = pll_enable;
      live_status[3] = clock_sync_q[CS_RATE_MSB:CS_RATE_LSB] > RATE_MAX_CODE;
      live_status[4] = rise_busy;
      live_status[5] = fall_busy;
   end

   // Registered read data, zero for unmapped addresses and idle cycles
   // Idle zero lets slaves share a wired-or bus
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_MISC_CONFIG: reg_rdata <= misc_config_q;
            ADDR_CLOCK_SYNC:  reg_rdata <= clock_sync_q;
            ADDR_SUPPLY_MON:  reg_rdata <= supply_mon_q;
            ADDR_IRQ_STATUS:  reg_rdata <= irq_status_q;
            ADDR_IRQ_MASK:    reg_rdata <= irq_mask_q;
            ADDR_LIVE_STATUS: reg_rdata <= live_status;
            default:          reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Configuration outputs straight from the register flops
   assign sync_input_pulldown        = misc_config_q[CFG_SYNC_PD_BIT];
   assign enable_pin_three_pulldown  = misc_config_q[CFG_ENABLE_PIN_THREE_PULLDOWN_BIT];
   assign enable_pin_two_pulldown    = misc_config_q[CFG_ENABLE_PIN_TWO_PULLDOWN_BIT];
   assign enable_pin_one_pulldown    = misc_config_q[CFG_ENABLE_PIN_ONE_PULLDOWN_BIT];
   assign thermal_alarm_level        = misc_config_q[CFG_THERM_BIT];
   assign dither_enable              = misc_config_q[CFG_DITHER_BIT];
   // Rate code passes as stored; the PLL reads freq = code + 1 MHz
   assign sync_input_rate            = clock_sync_q[CS_RATE_MSB:CS_RATE_LSB];
   assign supply_window_mode         = supply_mon_q[SM_WINDOW_BIT];
   assign analog_supply_check_enable = supply_mon_q[SM_ANALOG_BIT];
   assign monitor_two_check_enable   = supply_mon_q[SM_MON_TWO_BIT];
   assign monitor_one_check_enable   = supply_mon_q[SM_MON_ONE_BIT];
   assign stepup_check_enable        = supply_mon_q[SM_STEPUP_BIT];
   assign stepdown_one_check_enable  = supply_mon_q[SM_STEPDN1_BIT];
   assign stepdown_zero_check_enable = supply_mon_q[SM_STEPDN0_BIT];

endmodule // pcpc_regs

// file: pcpc_regs_asserts.sv
`timescale 1ns/1ps

module pcpc_regs_asserts
   import pcpc_pkg::*;
(
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] otp_clock_sync,
   input wire logic [7:0] otp_supply_mon,
   input wire logic       device_powered,
   input wire logic       sync_input_pin,
   input wire logic       sync_input_pulldown,
   input wire logic       enable_pin_one_pulldown,
   input wire logic       enable_pin_two_pulldown,
   input wire logic       enable_pin_three_pulldown,
   input wire logic       pll_enable,
   input wire logic       use_sync_clock,
   input wire logic [4:0] sync_input_rate,
   input wire logic       supply_window_mode,
   input wire logic       analog_supply_check_enable,
   input wire logic       monitor_two_check_enable,
   input wire logic       monitor_one_check_enable,
   input wire logic       stepup_check_enable,
   input wire logic       stepdown_one_check_enable,
   input wire logic       stepdown_zero_check_enable,
   input wire logic       rise_delay_done,
   input wire logic       irq
);
   logic       rdy_q;
   logic [7:0] mask_q;
   logic       wr_ok;
   logic [6:0] mon_bits;

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // Writes in the OTP load cycle are dropped, so only later ones count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) rdy_q <= 1'b0;
      else rdy_q <= 1'b1;
   end

   // Shadow of the interrupt mask, needed to know when irq may rise
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) mask_q <= 8'h00;
      else if (wr_ok && reg_addr == ADDR_IRQ_MASK) mask_q <= reg_wdata & IRQ_IMPL_MASK;
   end

   // Qualified write strobe and grouped monitor enables
   assign wr_ok    = rdy_q && reg_wr;
   assign mon_bits = {supply_window_mode, analog_supply_check_enable, monitor_two_check_enable,
                      monitor_one_check_enable, stepup_check_enable, stepdown_one_check_enable,
                      stepdown_zero_check_enable};

   AST_OTP_LOAD:
      assert property ($rose(rdy_q) |-> sync_input_rate == otp_clock_sync[4:0]
         && mon_bits == otp_supply_mon[6:0]) else $error("defaults not loaded from OTP");
   AST_PULLDOWNS:
      assert property (wr_ok && reg_addr == ADDR_MISC_CONFIG |=> {sync_input_pulldown,
         enable_pin_three_pulldown, enable_pin_two_pulldown, enable_pin_one_pulldown}
         == $past(reg_wdata[5:2])) else $error("pull-down selects do not follow write");
   AST_RATE_FIELD:
      assert property (wr_ok && reg_addr == ADDR_CLOCK_SYNC |=>
         sync_input_rate == $past(reg_wdata[4:0])) else $error("rate field wrong");
   AST_MONITOR_BITS:
      assert property (wr_ok && reg_addr == ADDR_SUPPLY_MON |=>
         mon_bits == $past(reg_wdata[6:0])) else $error("monitor enables wrong");
   AST_PLL_OFF:
      assert property (wr_ok && reg_addr == ADDR_CLOCK_SYNC && !reg_wdata[CS_PLL_EN_BIT]
         |=> ##1 !pll_enable && !use_sync_clock) else $error("PLL still on");
   AST_PLL_ON:
      assert property ((wr_ok && reg_addr == ADDR_CLOCK_SYNC && reg_wdata[CS_PLL_EN_BIT]) ##1
         (device_powered && !reg_wr) |=> pll_enable) else $error("PLL not enabled");
   AST_CLK_APPEAR:
      assert property (pll_enable && !use_sync_clock && sync_input_pin != $past(sync_input_pin)
         && mask_q[IRQ_CLK_APPEAR_BIT] && !reg_wr |-> ##[1:3] irq) else $error("no irq");
   AST_RECONFIG:
      assert property (wr_ok && reg_addr == ADDR_SUPPLY_MON && reg_wdata[6:0] != mon_bits
         && mask_q[IRQ_RECONFIG_BIT] |=> ##1 irq) else $error("no reconfig irq");
   AST_RD_IDLE:
      assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");

   // Main scenarios reached
   cover property (wr_ok && reg_addr == ADDR_SUPPLY_MON);
   cover property ($rose(irq));
   cover property (rise_delay_done);
   cover property ($rose(use_sync_clock));

endmodule // pcpc_regs_asserts

bind pcpc_regs pcpc_regs_asserts i_asserts (.*);

// file: pmic_clock_pgood_config_regs_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
   $display("unexpected at %0t ns: got %h want %h", $time, (a), (b)); end end

module pmic_clock_pgood_config_regs_tb;
   import pcpc_pkg::*;
   localparam int UNIT = 4;
   logic       clk, rstn, reg_wr, reg_rd, device_powered, sync_input_pin, delay_control;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, otp_misc_config, otp_clock_sync, otp_supply_mon;
   logic [3:0] rise_code, fall_code, c;
   logic [4:0] sync_input_rate;
   logic       sync_input_pulldown, enable_pin_one_pulldown, enable_pin_two_pulldown;
   logic       enable_pin_three_pulldown, thermal_alarm_level, dither_enable, pll_enable;
   logic       use_sync_clock, supply_window_mode, analog_supply_check_enable;
   logic       monitor_two_check_enable, monitor_one_check_enable, stepup_check_enable;
   logic       stepdown_one_check_enable, stepdown_zero_check_enable;
   logic       rise_delay_done, fall_delay_done, irq;
   logic [1:0] s;
   logic [7:0] mdl [3]; // Shadow of the three config registers
   logic [7:0] a, d, rd_val;
   int         errors, num_checks, seed, n;
   wire logic [3:0] pd_bits = {sync_input_pulldown, enable_pin_three_pulldown,
                               enable_pin_two_pulldown, enable_pin_one_pulldown};
   wire logic [6:0] mon_bits = {supply_window_mode, analog_supply_check_enable,
      monitor_two_check_enable, monitor_one_check_enable, stepup_check_enable,
      stepdown_one_check_enable, stepdown_zero_check_enable};

   pcpc_regs #(.UNIT_CYCLES(UNIT)) i_dut (.*);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Expected read data: shadow for config registers, zero when unmapped
   function automatic logic [7:0] exp_rd(input logic [7:0] ad);
      return (ad >= ADDR_MISC_CONFIG && ad <= ADDR_SUPPLY_MON) ? mdl[ad - ADDR_MISC_CONFIG] : 8'h00;
   endfunction

   // Expected timer length in cycles for a code and scale select
   function automatic int exp_delay(input logic [3:0] cd, input logic sc);
      return cd * UNIT * (sc ? 2 : 1);
   endfunction

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= ad;
      reg_wdata <= dt;
      @(posedge clk);
      reg_wr <= 1'b0;
      if (ad >= ADDR_MISC_CONFIG && ad <= ADDR_SUPPLY_MON) mdl[ad - ADDR_MISC_CONFIG] = dt;
      #1;
   endtask

   task automatic rd(input logic [7:0] ad);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= ad;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask

   // Every config output against the shadow copy
   task automatic chk_outs;
      `CHK(pd_bits, mdl[0][5:2])
      `CHK({thermal_alarm_level, dither_enable}, mdl[0][1:0])
      `CHK(sync_input_rate, mdl[1][4:0])
      `CHK(mon_bits, mdl[2][6:0])
   endtask

   // Bounded wait for irq; running out ends the run
   task automatic wait_irq;
      for (int i = 0; i < 8 && irq !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      `CHK(irq, 1'b1)
      if (irq !== 1'b1) complete_run();
   endtask

   // One control edge, then time the matching done pulse
   task automatic delay_run(input logic lvl, input logic [3:0] cd, input logic sc);
      @(posedge clk);
      delay_control <= lvl;
      rise_code     <= cd;
      fall_code     <= cd;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (n < 300 && (lvl ? rise_delay_done : fall_delay_done) !== 1'b1);
      `CHK(n >= exp_delay(cd, sc) + 3 && n <= exp_delay(cd, sc) + 4, 1'b1)
      if (n >= 300) complete_run();
   endtask

   initial begin
      seed = 34356;
      {errors, num_checks} = '0;
      {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, sync_input_pin, delay_control} = '0;
      {rise_code, fall_code} = '0;
      device_powered  = 1'b1;
      otp_misc_config = $random(seed);
      otp_clock_sync  = $random(seed) & 8'h9f;
      otp_supply_mon  = $random(seed);
      mdl = '{otp_misc_config, otp_clock_sync, otp_supply_mon};
      repeat (3) @(posedge clk);
      #1;
      `CHK(pd_bits, MISC_CONFIG_RST[5:2])
      @(posedge clk) rstn <= 1'b1;
      @(posedge clk);
      #1;
      chk_outs();
      // Random traffic over all config registers, reserved bits too
      for (int i = 0; i < 24; i++) begin
         a = ADDR_MISC_CONFIG + 8'({$random(seed)} % 3);
         d = $random(seed);
         if (a == ADDR_CLOCK_SYNC) d = d & 8'h9f;
         wr(a, d);
         chk_outs();
         rd(a);
         `CHK(rd_val, exp_rd(a))
      end
      rd(8'h30);
      `CHK(rd_val, exp_rd(8'h30))
      // Reserved rate codes are flagged in live status, valid ones not
      wr(ADDR_CLOCK_SYNC, 8'h18);
      rd(ADDR_LIVE_STATUS);
      `CHK(rd_val, 8'h08)
      wr(ADDR_CLOCK_SYNC, {3'b000, RATE_MAX_CODE});
      rd(ADDR_LIVE_STATUS);
      `CHK(rd_val, 8'h00)
      $display("register test done");
      // Reconfiguration event: masked, then unmasked, then cleared
      wr(ADDR_IRQ_STATUS, 8'h1f);
      wr(ADDR_SUPPLY_MON, ~mdl[2]);
      repeat (4) @(posedge clk);
      #1;
      `CHK(irq, 1'b0)
      rd(ADDR_IRQ_STATUS);
      `CHK(rd_val[IRQ_RECONFIG_BIT], 1'b1)
      wr(ADDR_IRQ_STATUS, 8'h04);
      wr(ADDR_IRQ_MASK, 8'h1f);
      wr(ADDR_SUPPLY_MON, mdl[2] ^ 8'h40);
      wait_irq();
      wr(ADDR_IRQ_STATUS, 8'h04);
      repeat (2) @(posedge clk);
      #1;
      `CHK(irq, 1'b0)
      $display("interrupt test done");
      // Sync clock appears and vanishes with the PLL on
      wr(ADDR_CLOCK_SYNC, {3'b010, mdl[1][4:0]});
      repeat (2) @(posedge clk);
      #1;
      `CHK({pll_enable, use_sync_clock}, 2'b10)
      repeat (8) @(posedge clk) sync_input_pin <= ~sync_input_pin;
      #1;
      wait_irq();
      `CHK(use_sync_clock, 1'b1)
      repeat (220) @(posedge clk);
      rd(ADDR_IRQ_STATUS);
      `CHK({use_sync_clock, rd_val[1:0]}, 3'b011)
      wr(ADDR_IRQ_STATUS, 8'h03);
      @(posedge clk) device_powered <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK(pll_enable, 1'b0)
      @(posedge clk) device_powered <= 1'b1;
      wr(ADDR_CLOCK_SYNC, {3'b000, mdl[1][4:0]});
      repeat (8) @(posedge clk) sync_input_pin <= ~sync_input_pin;
      repeat (4) @(posedge clk);
      #1;
      `CHK({pll_enable, use_sync_clock, irq}, 3'b000)
      $display("sync clock test done");
      // Startup and shutdown timers, both scales, end codes first
      for (int i = 0; i < 6; i++) begin
         c = (i < 2) ? 4'(i * 15) : 4'($random(seed));
         s = (i < 2) ? {2{i[0]}} : 2'($random(seed));
         wr(ADDR_MISC_CONFIG, {s, mdl[0][5:0]});
         delay_run(1'b1, c, s[1]);
         delay_run(1'b0, ~c, s[0]);
      end
      $display("delay test done");
      complete_run();
   end

endmodule // pmic_clock_pgood_config_regs_tb
